// >>> rtl/stp_sensor_cfg.sv
// threshold, persistence, gain and pulse configuration logic
`timescale 1ns/10ps
`default_nettype none
`include "stp_regs.svh"
module stp_sensor_cfg #(
   parameter int CYC_PER_US = `STP_US_NS / `STP_CLK_NS
) (
   input  wire logic            clk_i,
   input  wire logic            sys_rst_i,
   input  wire logic            ce_i,
   input  wire stp_pkg::stp_req_t req_i,
   output logic [7:0]           rdata_o,
   input  wire logic            light_valid_i,
   input  wire logic [15:0]     light_data_i,
   input  wire logic            light_irq_enable_i,
   input  wire logic            light_irq_clr_i,
   output logic                 light_irq_flag_o,
   input  wire logic            prox_valid_i,
   input  wire logic [15:0]     prox_raw_i,
   input  wire logic            prox_irq_clr_i,
   output logic                 prox_irq_o,
   output logic                 prox_low_breach_o,
   output logic                 prox_high_breach_o,
   output logic [15:0]          prox_result_o,
   output logic                 int_o,
   output logic                 int_oe_o,
   input  wire logic [7:0]      light_wait_time_i,
   input  wire logic [7:0]      prox_wait_time_i,
   output logic [11:0]          light_wait_span_o,
   output logic [11:0]          prox_wait_span_o,
   output logic [4:0]           prox_stage1_gain_o,
   output logic [4:0]           prox_stage2_gain_x2_o,
   input  wire logic            pulse_start_i,
   input  wire logic            near_sat_i,
   output logic                 emitter_o,
   output logic                 pulse_done_o
);
   import stp_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // register storage
   logic [15:0] light_hi_thr_q;   // committed light high threshold
   logic [7:0]  light_lo_buf_q;   // buffered low byte
   logic [13:0] prox_lo_thr_q;    // committed prox low threshold
   logic [7:0]  prox_lo_buf_q;
   logic [13:0] prox_hi_thr_q;    // committed prox high threshold
   logic [7:0]  prox_hi_buf_q;
   logic [7:0]  persistence_filters_q;       // persistence filters
   logic [7:0]  general_config_zero_q;       // general config zero
   logic [7:0]  prox_gain_config_q;          // gain config
   logic [7:0]  prox_pulse_count_config_q;   // pulse count and length upper
   logic [7:0]  prox_pulse_length_lower_q;   // pulse length lower
   logic [7:0]  config_six_q;                // config six
   logic        auto_pulse_control;          // auto pulse control active
   logic        wr_en;                       // qualified write

   assign auto_pulse_control = ~config_six_q[`STP_BIT_AUTO_OFF];
   assign wr_en  = ce_i & req_i.wr;

   // light threshold: low byte waits for the high byte
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         light_hi_thr_q <= 16'h0000;
         light_lo_buf_q <= 8'h00;
      end
      else if (wr_en)
      begin
         if (req_i.addr == `STP_OFS_LHT_LO)
            light_lo_buf_q <= req_i.wdata;
         if (req_i.addr == `STP_OFS_LHT_HI)
            light_hi_thr_q <= {req_i.wdata, light_lo_buf_q};
      end
   end

   // prox thresholds: with auto pulse off the low byte acts alone
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         prox_lo_thr_q <= 14'h0000;
         prox_lo_buf_q <= 8'h00;
         prox_hi_thr_q <= 14'h0000;
         prox_hi_buf_q <= 8'h00;
      end
      else if (wr_en)
      begin
         case (req_i.addr)
            `STP_OFS_PLT_LO:
            begin
               prox_lo_buf_q <= req_i.wdata;
               if (!auto_pulse_control)
                  prox_lo_thr_q[7:0] <= req_i.wdata;
            end
            `STP_OFS_PLT_HI:
               prox_lo_thr_q <= {req_i.wdata[5:0], prox_lo_buf_q};
            `STP_OFS_PHT_LO:
            begin
               prox_hi_buf_q <= req_i.wdata;
               if (!auto_pulse_control)
                  prox_hi_thr_q[7:0] <= req_i.wdata;
            end
            `STP_OFS_PHT_HI:
               prox_hi_thr_q <= {req_i.wdata[5:0], prox_hi_buf_q};
            default:
               ; // other offsets belong to plain registers
         endcase
      end
   end

   // plain configuration registers
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         persistence_filters_q     <= 8'h00;
         general_config_zero_q     <= `STP_RST_GENCONF;
         prox_gain_config_q        <= `STP_RST_GAINCONF;
         prox_pulse_count_config_q <= `STP_RST_PCOUNT;
         prox_pulse_length_lower_q <= `STP_RST_PLEN;
         config_six_q              <= `STP_RST_CONFSIX;
      end
      else if (wr_en)
      begin
         case (req_i.addr)
            `STP_OFS_PERSIST:  persistence_filters_q     <= req_i.wdata;
            `STP_OFS_GENCONF:  general_config_zero_q     <= req_i.wdata;
            `STP_OFS_GAINCONF: prox_gain_config_q        <= req_i.wdata;
            `STP_OFS_PCOUNT:   prox_pulse_count_config_q <= req_i.wdata;
            `STP_OFS_PLEN:     prox_pulse_length_lower_q <= req_i.wdata;
            `STP_OFS_CONFSIX:  config_six_q              <= req_i.wdata;
            default:        ; // unmapped writes are dropped
         endcase
      end
   end

   // read data, one cycle after the read strobe; unmapped reads zero
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         rdata_o <= 8'h00;
      else if (ce_i && req_i.rd)
      begin
         case (req_i.addr)
            `STP_OFS_LHT_LO: rdata_o <= light_hi_thr_q[7:0];
            `STP_OFS_LHT_HI: rdata_o <= light_hi_thr_q[15:8];
            `STP_OFS_PLT_LO: rdata_o <= prox_lo_thr_q[7:0];
            `STP_OFS_PLT_HI: rdata_o <= {2'b00, prox_lo_thr_q[13:8]};
            `STP_OFS_PHT_LO: rdata_o <= prox_hi_thr_q[7:0];
            `STP_OFS_PHT_HI: rdata_o <= {2'b00, prox_hi_thr_q[13:8]};
            `STP_OFS_PERSIST:  rdata_o <= persistence_filters_q;
            `STP_OFS_GENCONF:  rdata_o <= general_config_zero_q;
            `STP_OFS_GAINCONF: rdata_o <= prox_gain_config_q;
            `STP_OFS_PCOUNT:   rdata_o <= prox_pulse_count_config_q;
            `STP_OFS_PLEN:     rdata_o <= prox_pulse_length_lower_q;
            `STP_OFS_CONFSIX:  rdata_o <= config_six_q;
            default:         rdata_o <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // light persistence and flag
   // light persistence code to consecutive count
   function automatic logic [5:0] light_req(input logic [3:0] code);
      logic [5:0] c;
      c = {2'b00, code};
      if (code < 4'd2)
         light_req = 6'd1;
      else if (code < 4'd4)
         light_req = c;
      else
         light_req = 6'((c - 6'd3) * 6'd5);
   endfunction

   logic [5:0] light_cnt_q;   // consecutive out-of-range count
   logic [5:0] light_cnt_d;
   logic       light_out;     // result above threshold
   logic       light_hit;     // persistence reached this result
   logic       light_flag_q;
   logic       int_oe_q;

   // plain 16-bit compare; double-data mode relies on a zero upper byte
   assign light_out   = light_data_i > light_hi_thr_q;
   assign light_cnt_d = !light_out ? 6'd0 :
                        (&light_cnt_q) ? light_cnt_q : light_cnt_q + 6'd1;
   assign light_hit   = light_valid_i & light_out &
                        (light_cnt_d == light_req(persistence_filters_q[3:0]));

   // counter only moves on a new light result
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         light_cnt_q <= 6'd0;
      else if (ce_i && light_valid_i)
         light_cnt_q <= light_cnt_d;
   end

   // sticky flag, a new hit beats a clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         light_flag_q <= 1'b0;
         int_oe_q     <= 1'b0;
      end
      else if (ce_i)
      begin
         light_flag_q <= light_hit | (light_flag_q & ~light_irq_clr_i);
         int_oe_q     <= light_irq_enable_i &
                         (light_hit | (light_flag_q & ~light_irq_clr_i));
      end
   end

   assign light_irq_flag_o = light_flag_q;
   assign int_o            = 1'b0;      // open drain: only pulls low
   assign int_oe_o         = int_oe_q;

   ////////////////////////////////////////////////////////////////////
   // proximity compare and persistence
   logic [13:0] prox_cmp;     // value compared with the thresholds under auto pulse
   logic        prox_below;
   logic        prox_above;
   logic        prox_out;
   logic [3:0]  prox_cnt_q;
   logic [3:0]  prox_cnt_d;
   logic        prox_fire;
   logic [3:0]  prox_persist_setting;

   assign prox_persist_setting = persistence_filters_q[7:4];

   // auto pulse off compares the top 8 of the 10-bit value
   always_comb
   begin
      prox_cmp   = prox_raw_i[15:2];
      prox_below = 1'b0;
      prox_above = 1'b0;
      if (auto_pulse_control)
      begin
         prox_below = prox_cmp < prox_lo_thr_q;
         prox_above = prox_cmp > prox_hi_thr_q;
      end
      else
      begin
         prox_below = prox_raw_i[15:8] < prox_lo_thr_q[7:0];
         prox_above = prox_raw_i[15:8] > prox_hi_thr_q[7:0];
      end
   end

   assign prox_out   = prox_below | prox_above;
   assign prox_cnt_d = !prox_out ? 4'd0 :
                       (&prox_cnt_q) ? prox_cnt_q : prox_cnt_q + 4'd1;
   // code 0 fires every cycle, code 1 on any out-of-range result
   assign prox_fire  = prox_valid_i &
                       ((prox_persist_setting == 4'd0) |
                        (prox_out & (prox_persist_setting == 4'd1)) |
                        (prox_out & (prox_cnt_d == prox_persist_setting)));

   // consecutive counter for the prox filter
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         prox_cnt_q <= 4'd0;
      else if (ce_i && prox_valid_i)
         prox_cnt_q <= prox_cnt_d;
   end

   // sticky prox flags; set wins over clear
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         prox_irq_o         <= 1'b0;
         prox_low_breach_o  <= 1'b0;
         prox_high_breach_o <= 1'b0;
      end
      else if (ce_i)
      begin
         prox_irq_o         <= prox_fire | (prox_irq_o & ~prox_irq_clr_i);
         prox_low_breach_o  <= (prox_fire & prox_below) |
                               (prox_low_breach_o & ~prox_irq_clr_i);
         prox_high_breach_o <= (prox_fire & prox_above) |
                               (prox_high_breach_o & ~prox_irq_clr_i);
      end
   end

   // result width follows auto pulse and wide output bits
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         prox_result_o <= 16'h0000;
      else if (ce_i && prox_valid_i)
      begin
         if (!auto_pulse_control)
            prox_result_o <= {6'd0, prox_raw_i[15:6]};
         else if (general_config_zero_q[`STP_BIT_WIDE])
            prox_result_o <= prox_raw_i;
         else
            prox_result_o <= {2'b00, prox_cmp};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wait spans and gain decode
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         light_wait_span_o     <= 12'd0;
         prox_wait_span_o      <= 12'd0;
         prox_stage1_gain_o    <= 5'd4;
         prox_stage2_gain_x2_o <= 5'd20;
      end
      else if (ce_i)
      begin
         light_wait_span_o <= general_config_zero_q[`STP_BIT_LWAIT_X12] ?
            12'(light_wait_time_i) * 12'(`STP_WAIT_MULT) :
            12'(light_wait_time_i);
         prox_wait_span_o  <= general_config_zero_q[`STP_BIT_PWAIT_X12] ?
            12'(prox_wait_time_i) * 12'(`STP_WAIT_MULT) :
            12'(prox_wait_time_i);
         // codes above 100 clamp to 16x
         prox_stage1_gain_o <= (prox_gain_config_q[7:5] > 3'd4) ? 5'd16 :
                               5'(5'd1 << prox_gain_config_q[7:5]);
         // gain in half steps; forbidden code treated as 10x
         case (prox_gain_config_q[1:0])
            2'b00:   prox_stage2_gain_x2_o <= 5'd5;
            2'b01:   prox_stage2_gain_x2_o <= 5'd10;
            default: prox_stage2_gain_x2_o <= 5'd20;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // emitter pulse sequencer
   stp_pulse_st_t st_q;
   logic [13:0]   tmr_q;       // cycles left in this phase
   logic [6:0]    pulses_q;    // pulses sent this prox cycle
   logic [6:0]    max_pulses;  // field plus one
   logic [13:0]   len_cyc;     // pulse length in clock cycles
   logic [9:0]    pulse_len;
   logic          last_pulse;

   assign max_pulses = 7'(prox_pulse_count_config_q[5:0]) + 7'd1;
   assign pulse_len  = {prox_pulse_count_config_q[7:6], prox_pulse_length_lower_q};
   assign len_cyc    = 14'((pulse_len + 10'(`STP_LEN_EXTRA_US)) * CYC_PER_US);
   assign last_pulse = (pulses_q + 7'd1 == max_pulses) |
                       (auto_pulse_control & near_sat_i);

   // high for the pulse length, low for the same, repeated
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         st_q         <= ST_IDLE;
         tmr_q        <= 14'd0;
         pulses_q     <= 7'd0;
         emitter_o    <= 1'b0;
         pulse_done_o <= 1'b0;
      end
      else if (ce_i)
      begin
         pulse_done_o <= 1'b0;
         case (st_q)
            ST_IDLE:
               if (pulse_start_i)
               begin
                  st_q      <= ST_HIGH;
                  tmr_q     <= len_cyc - 14'd1;
                  pulses_q  <= 7'd0;
                  emitter_o <= 1'b1;
               end
            ST_HIGH:
               if (tmr_q != 14'd0)
                  tmr_q <= tmr_q - 14'd1;
               else
               begin
                  emitter_o <= 1'b0;
                  pulses_q  <= pulses_q + 7'd1;
                  tmr_q     <= len_cyc - 14'd1;
                  if (last_pulse)
                  begin
                     st_q         <= ST_IDLE;
                     pulse_done_o <= 1'b1;
                  end
                  else
                     st_q <= ST_LOW;
               end
            ST_LOW:
               if (tmr_q != 14'd0)
                  tmr_q <= tmr_q - 14'd1;
               else
               begin
                  st_q      <= ST_HIGH;
                  tmr_q     <= len_cyc - 14'd1;
                  emitter_o <= 1'b1;
               end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   logic [13:0] hi_len_q;   // length of the current emitter high

   // helper: counts cycles the emitter stays high
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || !emitter_o)
         hi_len_q <= 14'd0;
      else if (ce_i)
         hi_len_q <= hi_len_q + 14'd1;
   end

   sequence s_hi_write;
      wr_en && req_i.addr == `STP_OFS_LHT_HI;
   endsequence

   sequence s_plo_write_auto;
      wr_en && req_i.addr == `STP_OFS_PLT_LO && auto_pulse_control;
   endsequence

   sequence s_emitter_fall;
      ce_i && emitter_o && st_q == ST_HIGH && tmr_q == 14'd0;
   endsequence

   AST_LIGHT_COMMIT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_hi_write |=> light_hi_thr_q == {$past(req_i.wdata), $past(light_lo_buf_q)})
      else $error("light threshold not committed as one word");

   AST_PROX_LO_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_plo_write_auto |=> $stable(prox_lo_thr_q))
      else $error("prox low threshold changed on low byte write");

   AST_LIGHT_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && light_valid_i && light_out &&
      light_cnt_d == light_req(persistence_filters_q[3:0])
      |=> light_flag_q ##1 (int_oe_o || !$past(light_irq_enable_i, 2) || !ce_i))
      else $error("light flag missing after persistence met");

   AST_PERSISTENCE_FILTERS_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && prox_valid_i && !prox_out |=> prox_cnt_q == 4'd0)
      else $error("prox persistence count not cleared");

   AST_PROX_PERSIST_SETTING_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && prox_valid_i && prox_persist_setting == 4'd0 |=> prox_irq_o)
      else $error("prox interrupt missing with persistence zero");

   AST_AUTO_OFF_CMP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && prox_valid_i && !auto_pulse_control && prox_persist_setting == 4'd1 &&
      prox_raw_i[15:8] < prox_lo_thr_q[7:0] |=> prox_low_breach_o)
      else $error("8-bit low compare missed");

   AST_PULSE_COUNT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_emitter_fall ##0 !auto_pulse_control ##1 pulse_done_o |-> pulses_q == max_pulses)
      else $error("pulse train ended early without auto pulse");

   AST_PULSE_LEN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_emitter_fall |-> hi_len_q + 14'd1 == len_cyc)
      else $error("emitter pulse length wrong");

   AST_GAIN1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && prox_gain_config_q[7:5] == 3'd3 |=> prox_stage1_gain_o == 5'd8)
      else $error("stage one gain decode wrong");

endmodule
`default_nettype wire

// >>> rtl/stp_regs.svh
// register offsets, reset values, field positions and timing constants
// Notes on behaviour
// - light above high threshold plus persistence sets flag
// - light threshold low byte buffered, committed with high
// - double-data mode: host keeps high byte zero
// - auto pulse: 14-bit low prox threshold breach
// - auto pulse: 14-bit high prox threshold breach
// - auto pulse: prox threshold low byte buffered until high byte
// - auto pulse off: 10-bit data, 8-bit compare
// - prox persistence: 0 every cycle, else count
// - light persistence codes map to consecutive counts
// - count out-of-range results, clear when inside
// - wide output gives 16-bit prox result; auto pulse off keeps it 10-bit
// - wait long bits multiply wait by twelve
// - stage-one gain 1x to 16x, reset code 010
// - stage-two gain 2.5x, 5x, 10x; 10 forbidden
// - max pulse count is field plus one
// - auto pulse: stop early on near saturation
// - auto pulse off: send exactly programmed pulses
// - 10-bit pulse length, host keeps above 16us
`ifndef STP_REGS_SVH
`define STP_REGS_SVH
`define STP_OFS_LHT_LO   8'h86
`define STP_OFS_LHT_HI   8'h87
`define STP_OFS_PLT_LO   8'h88
`define STP_OFS_PLT_HI   8'h89
`define STP_OFS_PHT_LO   8'h8a
`define STP_OFS_PHT_HI   8'h8b
`define STP_OFS_PERSIST  8'h8c
`define STP_OFS_GENCONF  8'h8d
`define STP_OFS_GAINCONF 8'h8e
`define STP_OFS_PCOUNT   8'h8f
`define STP_OFS_PLEN     8'h90
`define STP_OFS_CONFSIX  8'hae
`define STP_RST_GENCONF  8'h10
`define STP_RST_GAINCONF 8'h43
`define STP_RST_PCOUNT   8'h00
`define STP_RST_PLEN     8'h20
`define STP_RST_CONFSIX  8'h76
`define STP_BIT_AUTO_OFF 6
`define STP_BIT_WIDE     7
`define STP_BIT_PWAIT_X12 3
`define STP_BIT_LWAIT_X12 2
`define STP_WAIT_MULT    12
`define STP_LEN_EXTRA_US 2
`define STP_US_NS        1000
`define STP_CLK_NS       100
`endif

// >>> rtl/stp_pkg.sv
// types shared by the threshold and persistence block
package stp_pkg;
   // one register access from the serial front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } stp_req_t;
   // emitter pulse sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HIGH,
      ST_LOW
   } stp_pulse_st_t;
endpackage

// >>> verification/stp_host_model.sv
// host-side model that issues register accesses on the request bus
`timescale 1ns/10ps
`default_nettype none
module stp_host_model (
   input  wire logic          clk_i,
   input  wire logic [7:0]    rdata_i,
   output var stp_pkg::stp_req_t req_o
);
   import stp_pkg::*;
   initial req_o = '0;
   ////////////////////////////////////////////////////////////////
   // one write: request held one edge, dropped at the next
   // callers send threshold low bytes before high bytes
   // callers keep the light upper byte zero in double-data mode
   // callers keep gain code 10 unused and pulse length above 16
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      req_o <= '0;
   endtask
   // one read: data registered at the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      req_o <= '0;
      #1;
      d = rdata_i;
   endtask
endmodule
`default_nettype wire

// >>> verification/sensor_threshold_persistence_config_tb.sv
// self-checking bench for the threshold and persistence block
`timescale 1ns/10ps
`default_nettype none
module sensor_threshold_persistence_config_tb;
   import stp_pkg::*;
   logic clk_i, sys_rst_i, lv, pv, len_i, lclr, pclr, start;
   logic [15:0] ld, pd, res;
   logic [7:0] rdata, rv, lwt, pwt;
   logic [11:0] lsp, psp;
   logic [4:0] g1, g2;
   logic lflag, pirq, plo, phi, io, ioe, em, done, ns;
   stp_req_t req;
   int n_errors, total_checks, hi;
   localparam logic [7:0] RA [7] = '{8'h8d, 8'h8e, 8'h8f, 8'h90, 8'hae, 8'h89, 8'h91};
   localparam logic [7:0] RE [7] = '{8'h10, 8'h43, 8'h00, 8'h20, 8'h76, 8'h00, 8'h00};
   stp_host_model u_stp_host_model (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
   stp_sensor_cfg #(.CYC_PER_US(1)) u_stp_sensor_cfg (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .req_i(req), .rdata_o(rdata),
      .light_valid_i(lv), .light_data_i(ld), .light_irq_enable_i(len_i),
      .light_irq_clr_i(lclr), .light_irq_flag_o(lflag), .prox_valid_i(pv),
      .prox_raw_i(pd), .prox_irq_clr_i(pclr), .prox_irq_o(pirq),
      .prox_low_breach_o(plo), .prox_high_breach_o(phi), .prox_result_o(res),
      .int_o(io), .int_oe_o(ioe), .light_wait_time_i(lwt), .prox_wait_time_i(pwt),
      .light_wait_span_o(lsp), .prox_wait_span_o(psp), .prox_stage1_gain_o(g1),
      .prox_stage2_gain_x2_o(g2), .pulse_start_i(start), .near_sat_i(ns),
      .emitter_o(em), .pulse_done_o(done));
   ////////////////////////////////////////////////////////////////
   // 10 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // read a register and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      u_stp_host_model.rd(a, rv);
      chk({8'h00, rv}, {8'h00, e});
   endtask
   // one result pulse on the light (p=0) or proximity (p=1) side
   task automatic put(input bit p, input logic [15:0] d);
      @(posedge clk_i);
      if (p)
      begin
         pv <= 1'b1;
         pd <= d;
      end
      else
      begin
         lv <= 1'b1;
         ld <= d;
      end
      @(posedge clk_i);
      lv <= 1'b0;
      pv <= 1'b0;
      #1;
   endtask
   // one-cycle clear pulse on both flag groups
   task automatic clr();
      @(posedge clk_i);
      lclr <= 1'b1;
      pclr <= 1'b1;
      @(posedge clk_i);
      lclr <= 1'b0;
      pclr <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // one pulse train; returns the number of emitter-high cycles
   task automatic train(output int n);
      @(posedge clk_i);
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      n = 1;
      for (int i = 0; i < 200; i++)
      begin
         @(posedge clk_i);
         #1;
         if (done === 1'b1)
            break;
         n += int'(em === 1'b1);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial
   begin
      #5000000;
      n_errors++;
      finish_test();
   end
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      sys_rst_i = 1'b1;
      {lv, pv, lclr, pclr, start, ns} = '0;
      len_i = 1'b1;
      ld = '0;
      pd = '0;
      lwt = 8'h05;
      pwt = 8'h07;
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) rchk(RA[i], RE[i]);
      chk({g1, 3'b000, g2}, {5'd4, 3'b000, 5'd20});
      u_stp_host_model.wr(8'h8e, 8'h80);
      clr();
      chk({g1, 3'b000, g2}, {5'd16, 3'b000, 5'd5});
      u_stp_host_model.wr(8'h8e, 8'h21);
      clr();
      chk({g1, 3'b000, g2}, {5'd2, 3'b000, 5'd10});
      // light threshold 0x1234 committed by the upper byte
      u_stp_host_model.wr(8'h86, 8'h34);
      u_stp_host_model.wr(8'h87, 8'h12);
      put(0, 16'h1234);
      chk({lflag, ioe}, 2'b00);
      put(0, 16'h1235);
      chk({lflag, ioe}, 2'b11);
      u_stp_host_model.wr(8'h86, 8'h00);
      rchk(8'h86, 8'h34);
      // light persistence code 4: five in a row, reset by an inside result
      u_stp_host_model.wr(8'h8c, 8'h04);
      put(0, 16'h0001);
      clr();
      repeat (4) put(0, 16'hf000);
      put(0, 16'h0001);
      repeat (4) put(0, 16'hf000);
      chk({15'h0, lflag}, 16'h0);
      put(0, 16'hf000);
      chk({15'h0, lflag}, 16'h1);
      // auto pulse off: 8-bit compare on the top of the 10-bit view
      u_stp_host_model.wr(8'h8a, 8'h40);
      clr();
      put(1, 16'h4000);
      chk({13'h0, pirq, plo, phi}, 16'h0004);
      put(1, 16'h4100);
      chk({13'h0, pirq, plo, phi}, 16'h0005);
      chk(res, 16'h0104);
      // auto pulse on: 14-bit thresholds, upper bits 7:6 read zero
      u_stp_host_model.wr(8'hae, 8'h36);
      u_stp_host_model.wr(8'h88, 8'h00);
      u_stp_host_model.wr(8'h89, 8'hd0);
      u_stp_host_model.wr(8'h8a, 8'hfe);
      u_stp_host_model.wr(8'h8b, 8'h3f);
      rchk(8'h89, 8'h10);
      clr();
      put(1, 16'h2000);
      chk({13'h0, pirq, plo, phi}, 16'h0006);
      chk(res, 16'h0800);
      u_stp_host_model.wr(8'h8d, 8'h90);
      put(1, 16'hfffc);
      chk({13'h0, pirq, plo, phi}, 16'h0007);
      chk(res, 16'hfffc);
      // wait multipliers
      u_stp_host_model.wr(8'h8d, 8'h18);
      clr();
      chk({4'h0, psp}, 16'd84);
      chk({4'h0, lsp}, 16'd5);
      u_stp_host_model.wr(8'h8d, 8'h14);
      clr();
      chk({4'h0, lsp}, 16'd60);
      // two pulses of length 15: 17 cycles each at one cycle per us
      u_stp_host_model.wr(8'h8f, 8'h01);
      u_stp_host_model.wr(8'h90, 8'h0f);
      train(hi);
      chk(16'(hi), 16'd34);
      chk({15'h0, em}, 16'h0);
      // near saturation ends an auto pulse train after one pulse
      ns <= 1'b1;
      train(hi);
      chk(16'(hi), 16'd17);
      // auto pulse off ignores near saturation
      u_stp_host_model.wr(8'hae, 8'h76);
      train(hi);
      chk(16'(hi), 16'd34);
      finish_test();
   end
endmodule
`default_nettype wire
